// ==== src/period_timer_mode_control.sv ====
// period timer mode selection and start/stop/reset control
//
// Summary of operation
// R1: mode[4:3] picks free-run, one-shot, monostable; 11 is reserved
// R2: trigger source spaces edges six timer clocks apart
// R3: trigger source holds triggering level three timer clocks
// R4: debug mode freezes the trigger input, ignoring all activity
// R5: mode 00000 counts while run bit set, no external reset
// R6: 00001/00010 count only with run set and trigger high/low
// R7: 00011..00101 reset count on any/rising/falling trigger edge
// R8: 00110/00111 hold counter reset while trigger low/high
// R9: 01000 starts at run set, stops at run clear or match
// R10: 01001..01011 start on rising/falling/any edge after run set
// R11: edge modes need a fresh edge after run is set again
// R12: 01100/01101 start and later reset on rising/falling edges
// R13: 01110/01111 edge start, level holds reset
// R14: one-shot: clock after match clears run, counter stops at 00h
// R15: 10001..10011 monostable start on edges; 10000 reserved
// R16: edge monostable (10001..10011): clock after match stops at 00h, run stays set
// R17: 10110/10111 level start, opposite level resets; 100/101 reserved
// R18: increment each tick; match clears count next tick, bumps post
// R19: count/control write, reset or trigger reset clear pre/post
// R20: device reset clears count and sets period to all ones
// R21: hardware clear of run is visible at run_state at once
// R22: reserved modes halt counting, resetting and outputs
`timescale 1ns/100ps
`include "period_timer_consts.svh"
module period_timer_mode_control
  import period_timer_pkg::*;
#(
  parameter int CW = 8,  // counter width
  parameter int PW = 7,  // prescaler width
  parameter int QW = 4   // postscaler width
) (
  input  wire logic          clk,               // timer clock
  input  wire logic          rst,               // async reset
  input  wire logic [4:0]    mode,              // mode field
  input  wire logic          run_set,           // software sets run bit
  input  wire logic          run_clr,           // software clears run bit
  input  wire logic          ctrl_wr,           // control register write
  input  wire logic          count_wr,          // count register write
  input  wire logic [CW-1:0] count_wdata,       // count write data
  input  wire logic          period_wr,         // period write
  input  wire logic [CW-1:0] period_wdata,      // period write data
  input  wire logic [PW-1:0] prescale_select,   // prescale divide - 1
  input  wire logic [QW-1:0] postscale_select,  // postscale divide - 1
  input  wire logic          debug_mode,        // debug freeze
  input  wire logic          ext_trigger_input, // external trigger pin
  output logic               run_state,         // run bit readback
  output logic [CW-1:0]      count_value,       // counter
  output logic [CW-1:0]      period_value,      // period register
  output logic               period_match,      // match pulse
  output logic               postscaled_out     // postscaled pulse
);
  // ------------------------------------------------------------
  // trigger conditioning
  // ------------------------------------------------------------
  logic lvl, rise, fall;
  trig_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .pin    (ext_trigger_input),
    .freeze (debug_mode),  // [R4]
    .level  (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic [1:0] fam;
  logic [2:0] var3;
  logic       reserved, edge_start, edge_hit, gate_ok, hold_rst, edge_rst;
  logic       lvl_start;
  assign fam  = mode[4:3];
  assign var3 = mode[2:0];

  always_comb begin
    reserved   = 1'b0;
    edge_start = 1'b0;
    edge_hit   = 1'b0;
    gate_ok    = 1'b1;
    hold_rst   = 1'b0;
    edge_rst   = 1'b0;
    lvl_start  = 1'b0;
    case (fam)  // [R1]
      `FAM_FREE: begin
        case (var3)
          3'h1: gate_ok = lvl;                        // [R6]
          3'h2: gate_ok = ~lvl;                       // [R6]
          3'h3: edge_rst = rise | fall;               // [R7]
          3'h4: edge_rst = rise;                      // [R7]
          3'h5: edge_rst = fall;                      // [R7]
          3'h6: hold_rst = ~lvl;                      // [R8]
          3'h7: hold_rst = lvl;                       // [R8]
          default: gate_ok = 1'b1;                    // [R5]
        endcase
      end
      `FAM_ONESHOT: begin
        case (var3)
          3'h0: edge_start = 1'b0;                    // [R9]
          3'h1: begin edge_start = 1'b1; edge_hit = rise; end // [R10]
          3'h2: begin edge_start = 1'b1; edge_hit = fall; end // [R10]
          3'h3: begin
            edge_start = 1'b1;
            edge_hit   = rise | fall;                 // [R10]
          end
          3'h4: begin
            edge_start = 1'b1;
            edge_hit   = rise;
            edge_rst   = rise;                        // [R12]
          end
          3'h5: begin
            edge_start = 1'b1;
            edge_hit   = fall;
            edge_rst   = fall;                        // [R12]
          end
          3'h6: begin
            edge_start = 1'b1;
            edge_hit   = rise;
            hold_rst   = ~lvl;                        // [R13]
          end
          3'h7: begin
            edge_start = 1'b1;
            edge_hit   = fall;
            hold_rst   = lvl;                         // [R13]
          end
          default: reserved = 1'b1;
        endcase
      end
      `FAM_MONO: begin
        case (var3)
          3'h1: begin edge_start = 1'b1; edge_hit = rise; end // [R15]
          3'h2: begin edge_start = 1'b1; edge_hit = fall; end // [R15]
          3'h3: begin
            edge_start = 1'b1;
            edge_hit   = rise | fall;                 // [R15]
          end
          3'h6: begin
            lvl_start = 1'b1;
            hold_rst  = ~lvl;                         // [R17]
          end
          3'h7: begin
            lvl_start = 1'b1;
            hold_rst  = lvl;                          // [R17]
          end
          default: reserved = 1'b1;                   // [R15] [R17]
        endcase
      end
      default: reserved = 1'b1;                       // [R1] [R22]
    endcase
  end

  logic stop_at_match, clear_run_at_match;
  // level one-shot (10 11x) behaves as one-shot: run cleared at match
  assign stop_at_match      = (fam != `FAM_FREE);
  assign clear_run_at_match = (fam == `FAM_ONESHOT) | lvl_start;

  // ------------------------------------------------------------
  // prescaler tick
  // ------------------------------------------------------------
  logic [PW-1:0] pre_r, pre_nxt;
  logic          tick;
  assign tick = (pre_r == prescale_select);

  // ------------------------------------------------------------
  // run control and counter
  // ------------------------------------------------------------
  run_state_type st_r, st_nxt;
  logic          run_r, run_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt, per_r, per_nxt;
  logic [QW-1:0] post_r, post_nxt;
  logic          pm_r, pm_nxt, po_r, po_nxt, match_pend_r, mp_nxt;
  logic          trig_reset, counting;

  assign trig_reset = run_r & ~reserved & (edge_rst | hold_rst);

  always_comb begin
    run_nxt  = run_r;
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    per_nxt  = per_r;
    post_nxt = post_r;
    pre_nxt  = tick ? `PRE_RESET : pre_r + 1'b1;
    pm_nxt   = 1'b0;
    po_nxt   = 1'b0;
    mp_nxt   = match_pend_r;
    counting = 1'b0;
    if (run_set)
      run_nxt = 1'b1;
    if (run_clr)
      run_nxt = 1'b0;
    if (period_wr)
      per_nxt = period_wdata;
    case (st_r)
      ST_IDLE: begin
        if (run_r && !reserved)
          st_nxt = (edge_start || lvl_start) ? ST_ARM : ST_RUN;
      end
      ST_ARM: begin
        // fresh edge or start level needed after run set
        if (!run_r || reserved)
          st_nxt = ST_IDLE;                           // [R11]
        else if (edge_hit || (lvl_start && !hold_rst))
          st_nxt = ST_RUN;                            // [R10] [R17]
      end
      ST_RUN: begin
        if (!run_r || reserved)
          st_nxt = ST_IDLE;                           // [R9] [R11] [R22]
        else
          counting = gate_ok & ~hold_rst;             // [R5] [R6]
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (trig_reset) begin
      cnt_nxt  = `COUNT_RESET;                        // [R7] [R8]
      pre_nxt  = `PRE_RESET;                          // [R19]
      post_nxt = `POST_RESET;
      mp_nxt   = 1'b0;
      counting = 1'b0;
    end
    if (counting && tick) begin
      if (match_pend_r) begin
        cnt_nxt = `COUNT_RESET;                       // [R18]
        mp_nxt  = 1'b0;
        if (stop_at_match) begin
          st_nxt = (edge_start || lvl_start) ? ST_ARM : ST_IDLE; // [R16]
          if (clear_run_at_match) begin
            run_nxt = 1'b0;                           // [R14] [R21]
            st_nxt  = ST_IDLE;
          end
        end
      end else if (cnt_r == per_r) begin
        mp_nxt = 1'b1;
        pm_nxt = 1'b1;                                // [R18]
        if (post_r == postscale_select) begin
          post_nxt = `POST_RESET;
          po_nxt   = 1'b1;
        end else
          post_nxt = post_r + 1'b1;
      end else
        cnt_nxt = cnt_r + 1'b1;                       // [R18]
    end
    if (count_wr) begin
      cnt_nxt = count_wdata;
      mp_nxt  = 1'b0;
    end
    if (count_wr || ctrl_wr) begin
      pre_nxt  = `PRE_RESET;                          // [R19]
      post_nxt = `POST_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r         <= ST_IDLE;
      run_r        <= 1'b0;
      cnt_r        <= `COUNT_RESET;                   // [R20]
      per_r        <= `PERIOD_RESET;                  // [R20]
      post_r       <= `POST_RESET;                    // [R19]
      pre_r        <= `PRE_RESET;
      pm_r         <= 1'b0;
      po_r         <= 1'b0;
      match_pend_r <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      run_r        <= run_nxt;
      cnt_r        <= cnt_nxt;
      per_r        <= per_nxt;
      post_r       <= post_nxt;
      pre_r        <= pre_nxt;
      pm_r         <= pm_nxt;
      po_r         <= po_nxt;
      match_pend_r <= mp_nxt;
    end
  end

  assign run_state      = run_r;
  assign count_value    = cnt_r;
  assign period_value   = per_r;
  assign period_match   = pm_r;
  assign postscaled_out = po_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_reserved_halt: assert property (@(posedge clk) disable iff (rst)
    reserved && !count_wr |=> $stable(cnt_r) || cnt_r == `COUNT_RESET)
    else $error("reserved mode changed count"); // [R22]
  a_oneshot_clear: assert property (@(posedge clk) disable iff (rst)
    counting && tick && match_pend_r && fam == `FAM_ONESHOT && !run_set
    && !count_wr |=> !run_r && cnt_r == `COUNT_RESET)
    else $error("one-shot did not clear run"); // [R14]
  a_mono_keeps: assert property (@(posedge clk) disable iff (rst)
    counting && tick && match_pend_r && fam == `FAM_MONO && !lvl_start
    && !run_clr && !count_wr |=> run_r && cnt_r == `COUNT_RESET)
    else $error("monostable dropped run"); // [R16]
  a_edge_reset: assert property (@(posedge clk) disable iff (rst)
    trig_reset && !count_wr |=> cnt_r == `COUNT_RESET && post_r == 4'h0)
    else $error("trigger reset missed"); // [R7]
  a_gate_hold: assert property (@(posedge clk) disable iff (rst)
    st_r == ST_RUN && !gate_ok && !count_wr && !trig_reset
    |=> $stable(cnt_r))
    else $error("gate did not hold count"); // [R6]
  a_swgate_count: assert property (@(posedge clk) disable iff (rst)
    mode == 5'h00 && st_r == ST_RUN && run_r && tick && !match_pend_r
    && cnt_r != per_r && !count_wr |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("software gate did not count"); // [R5]
  a_match_wrap: assert property (@(posedge clk) disable iff (rst)
    counting && tick && cnt_r == per_r && !match_pend_r && !count_wr
    && !trig_reset |=> period_match ##0 match_pend_r)
    else $error("match not flagged"); // [R18]
  a_arm_wait: assert property (@(posedge clk) disable iff (rst)
    st_r == ST_ARM && !edge_hit && !lvl_start && run_r && !reserved
    |=> st_r == ST_ARM)
    else $error("started without edge"); // [R10]
  a_ctrl_clr: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> pre_r == 7'h00 && post_r == 4'h0)
    else $error("prescaler not cleared"); // [R19]

  c_oneshot: cover property (@(posedge clk) disable iff (rst)
    fam == `FAM_ONESHOT && $fell(run_r));
  c_mono: cover property (@(posedge clk) disable iff (rst)
    fam == `FAM_MONO && st_r == ST_ARM && edge_hit);
  c_hw_reset: cover property (@(posedge clk) disable iff (rst)
    trig_reset && cnt_r != `COUNT_RESET);
endmodule

// ==== src/period_timer_consts.svh ====
// constants for the period timer mode control block
`ifndef PERIOD_TIMER_CONSTS_SVH
`define PERIOD_TIMER_CONSTS_SVH
`define FAM_FREE       2'h0
`define FAM_ONESHOT    2'h1
`define FAM_MONO       2'h2
`define PERIOD_RESET   8'hff
`define COUNT_RESET    8'h00
`define POST_RESET     4'h0
`define PRE_RESET      7'h00
`endif

// ==== src/period_timer_pkg.sv ====
// types for the period timer mode control block
package period_timer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_RUN  = 3'b100
  } run_state_type;
endpackage

// ==== src/trig_sync.sv ====
// trigger synchroniser and edge detector
`timescale 1ns/100ps
module trig_sync (
  input  wire logic clk,     // timer clock
  input  wire logic rst,     // async reset
  input  wire logic pin,     // raw external trigger
  input  wire logic freeze,  // debug: hold sampled level
  output logic      level,   // synchronised level
  output logic      rise,    // rising edge pulse
  output logic      fall     // falling edge pulse
);
  logic s1_r, s2_r, lvl_r, lvl_nxt;

  always_comb begin
    lvl_nxt = freeze ? lvl_r : s2_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r  <= pin;
      s2_r  <= s1_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_nxt;
  assign rise  = lvl_nxt & ~lvl_r;
  assign fall  = ~lvl_nxt & lvl_r;
endmodule

// ==== testbench/trig_source.sv ====
// external trigger source model that paces its edges
`timescale 1ns/100ps
module trig_source (
  input  wire logic clk,   // timer clock
  input  wire logic rst,   // async reset
  input  wire logic want,  // level the bench asks for
  output logic      pin    // trigger pin
);
  logic [2:0] gap_r;
  logic [2:0] gap_nxt;
  logic       pin_r;
  logic       pin_nxt;
  // ----------------------------------------------------------
  // edge pacing
  // ----------------------------------------------------------
  // a late request is delayed, never dropped; six clocks of
  // spacing also keep every level three clocks or longer
  always_comb begin
    pin_nxt = pin_r;
    gap_nxt = (gap_r == 3'h6) ? gap_r : gap_r + 3'h1;
    if (want != pin_r && gap_r == 3'h6) begin
      pin_nxt = want;
      gap_nxt = 3'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r <= 3'h6;
      pin_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      pin_r <= pin_nxt;
    end
  end
  assign pin = pin_r;
endmodule

// ==== testbench/period_timer_mode_control_tb.sv ====
// self-checking bench for the period timer mode control
`timescale 1ns/100ps
module period_timer_mode_control_tb;
  import period_timer_pkg::*;
  logic       clk;
  logic       rst;
  logic       run_set;
  logic       run_clr;
  logic       count_wr;
  logic       period_wr;
  logic       ctrl_wr;
  logic [6:0] pre_sel;
  logic [3:0] post_sel;
  logic       debug_mode;
  logic       want;
  logic       trig;
  logic [4:0] mode;
  logic [7:0] count_wdata;
  logic [7:0] period_wdata;
  logic       run_state;
  logic [7:0] count_value;
  logic [7:0] period_value;
  logic       period_match;
  logic       postscaled_out;
  logic [7:0] held;
  logic [4:0] gm [4] = '{5'h01, 5'h02, 5'h06, 5'h07};
  logic [4:0] rm [3] = '{5'h10, 5'h14, 5'h18};
  logic [4:0] em [2] = '{5'h03, 5'h05};
  logic [4:0] sm [4] = '{5'h0a, 5'h0b, 5'h12, 5'h13};
  logic       z;
  int         n_fail = 0;
  int         checks = 0;
  int         n_match = 0;
  int         n_post = 0;
  int         m0;
  int         p0;
  // ----------------------------------------------------------
  // design and trigger source
  // ----------------------------------------------------------
  period_timer_mode_control DUT (
    .clk(clk), .rst(rst), .mode(mode), .run_set(run_set),
    .run_clr(run_clr), .ctrl_wr(ctrl_wr), .count_wr(count_wr),
    .count_wdata(count_wdata), .period_wr(period_wr),
    .period_wdata(period_wdata), .prescale_select(pre_sel),
    .postscale_select(post_sel), .debug_mode(debug_mode),
    .ext_trigger_input(trig), .run_state(run_state),
    .count_value(count_value), .period_value(period_value),
    .period_match(period_match), .postscaled_out(postscaled_out)
  );
  trig_source src (.clk(clk), .rst(rst), .want(want), .pin(trig));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (period_match === 1'b1) n_match++;
    if (postscaled_out === 1'b1) n_post++;
  end
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  // fresh reset per scenario so no state leaks between modes
  task automatic start(input logic [4:0] m, input logic [7:0] p);
    rst = 1'b1;
    want = 1'b0;
    debug_mode = 1'b0;
    step(2);
    rst = 1'b0;
    mode = m;
    period_wdata = p;
    period_wr = 1'b1;
    step(1);
    period_wr = 1'b0;
    run_set = 1'b1;
    step(1);
    run_set = 1'b0;
    m0 = n_match;
    p0 = n_post;
  endtask
  task automatic end_of_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_of_test;
  end
  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    {rst, run_set, run_clr, count_wr, period_wr, debug_mode, want} = 7'h40;
    mode = 5'h00;
    ctrl_wr = 1'b0;
    pre_sel = 7'h00;
    post_sel = 4'h0;
    count_wdata = 8'h37;
    period_wdata = 8'hff;
    step(4);
    rst = 1'b0;
    step(1);
    check(count_value === 8'h00 && period_value === 8'hff, "reset");
    check(run_state === 1'b0, "run bit after reset");
    count_wr = 1'b1;
    step(1);
    count_wr = 1'b0;
    check(count_value === 8'h37, "count load");
    start(5'h00, 8'h02);
    check(run_state === 1'b1, "run bit set");
    step(2);
    check(count_value === 8'h01, "first count");
    step(1);
    check(count_value === 8'h02, "second count");
    step(1);
    check(count_value === 8'h02 && period_match === 1'b1, "match");
    step(1);
    check(count_value === 8'h00, "wrap to zero");
    run_clr = 1'b1;
    step(2);
    run_clr = 1'b0;
    held = count_value;
    step(5);
    check(count_value === held, "halt on run clear");
    check(n_post > 0, "postscaled pulse");
    start(5'h08, 8'h02);
    step(5);
    check(run_state === 1'b0 && count_value === 8'h00, "one-shot");
    step(6);
    check(count_value === 8'h00 && n_match == m0 + 1, "stays");
    foreach (gm[i]) begin
      z = (gm[i] == 5'h01 || gm[i] == 5'h06);
      start(gm[i], 8'hff);
      step(20);
      check((count_value === 8'h00) === z, "low input");
      want = 1'b1;
      step(20);
      held = count_value;
      step(4);
      if (gm[i] == 5'h02)
        check(held !== 8'h00 && count_value === held, "gate low");
      else
        check((count_value === 8'h00) === !z, "high input");
      check(count_value !== held || !z, "still counting");
    end
    start(5'h04, 8'hff);
    step(30);
    held = count_value;
    want = 1'b1;
    step(8);
    check(held > 8'h10 && count_value < 8'h08, "edge reset");
    foreach (em[i]) begin
      start(em[i], 8'hff);
      want = 1'b1;
      step(30);
      held = count_value;
      want = 1'b0;
      step(8);
      check(held > 8'h10 && count_value < 8'h08, "fall reset");
    end
    start(5'h09, 8'h0a);
    step(10);
    check(count_value === 8'h00 && run_state === 1'b1, "armed");
    want = 1'b1;
    step(30);
    check(run_state === 1'b0 && n_match == m0 + 1, "edge shot");
    start(5'h09, 8'hff);
    want = 1'b1;
    step(15);
    run_clr = 1'b1;
    step(1);
    run_clr = 1'b0;
    step(1);
    held = count_value;
    run_set = 1'b1;
    step(1);
    run_set = 1'b0;
    step(10);
    check(held !== 8'h00 && count_value === held, "no fresh edge");
    start(5'h11, 8'h0a);
    want = 1'b1;
    step(30);
    check(run_state === 1'b1 && count_value === 8'h00, "mono");
    want = 1'b0;
    step(10);
    want = 1'b1;
    step(30);
    check(n_match == m0 + 2, "mono retrigger");
    foreach (sm[i]) begin
      z = sm[i][4];
      start(sm[i], 8'h0a);
      want = 1'b1;
      step(10);
      want = 1'b0;
      step(40);
      check(count_value === 8'h00 && run_state === z, "edge start");
      check(n_match == m0 + 1, "one period");
    end
    start(5'h0c, 8'hff);
    want = 1'b1;
    step(20);
    want = 1'b0;
    step(20);
    held = count_value;
    want = 1'b1;
    step(8);
    check(held > 8'h10 && count_value < 8'h08, "edge restart");
    check(run_state === 1'b1, "run kept");
    start(5'h0e, 8'hff);
    want = 1'b1;
    step(20);
    held = count_value;
    want = 1'b0;
    step(8);
    check(held > 8'h08 && count_value === 8'h00, "low holds reset");
    check(run_state === 1'b1, "run kept low");
    start(5'h16, 8'h0a);
    step(10);
    check(count_value === 8'h00 && run_state === 1'b1, "held armed");
    want = 1'b1;
    step(30);
    check(run_state === 1'b0 && n_match == m0 + 1, "level shot");
    start(5'h09, 8'h0a);
    debug_mode = 1'b1;
    want = 1'b1;
    step(30);
    check(count_value === 8'h00 && n_match == m0, "debug freeze");
    foreach (rm[i]) begin
      start(rm[i], 8'h02);
      want = 1'b1;
      step(20);
      check(count_value === 8'h00 && n_match == m0, "reserved");
    end
    pre_sel = 7'h03;
    start(5'h00, 8'hff);
    step(20);
    ctrl_wr = 1'b1;
    step(1);
    held = count_value;
    step(7);
    check(held !== 8'h00 && count_value === held, "ctrl write");
    ctrl_wr = 1'b0;
    step(3);
    check(count_value === held, "prescale wait");
    step(1);
    check(count_value === held + 8'h01, "prescale tick");
    pre_sel = 7'h00;
    post_sel = 4'h1;
    start(5'h00, 8'h02);
    step(40);
    check(n_match - m0 > 3, "matches");
    check(n_post - p0 == (n_match - m0) / 2, "postscale");
    end_of_test;
  end
endmodule
